// File: common/hmrt_pkg.sv
// shared constants and types of the host mac filter and retry block
`default_nettype none
package hmrt_pkg;
   // ----------------------------------------------------------------
   // register indices (byte address is four times the index)
   // ----------------------------------------------------------------
   localparam logic [9:0]  IDX_CONTROL    = 10'h001;
   localparam logic [9:0]  IDX_ADDR_HIGH  = 10'h002;
   localparam logic [9:0]  IDX_ADDR_LOW   = 10'h003;
   localparam logic [9:0]  IDX_HASH_HIGH  = 10'h004;
   localparam logic [9:0]  IDX_HASH_LOW   = 10'h005;
   localparam logic [9:0]  IDX_WAKEUP     = 10'h00c;
   localparam logic [9:0]  IDX_TX_STATUS  = 10'h010;
   localparam int unsigned PADDR_W        = 12;
   localparam int unsigned DATA_W         = 32;
   // ----------------------------------------------------------------
   // control fields, reset values, wakeup and tx status bits
   // ----------------------------------------------------------------
   localparam int unsigned BIT_PASS_BAD   = 16;
   localparam int unsigned BIT_HASH_ONLY  = 15;
   localparam int unsigned BIT_HASH_PERF  = 13;
   localparam int unsigned BIT_BROADCAST_DISABLE_DIS  = 11;
   localparam int unsigned BIT_RETRY_DIS  = 10;
   localparam int unsigned BIT_PAD_STRIP  = 8;
   localparam logic [31:0] CONTROL_MASK   = 32'h0001_ad00;
   localparam logic [31:0] CONTROL_RESET  = 32'h0000_0000;
   localparam int unsigned BIT_WAKE_EN    = 0;
   localparam int unsigned BIT_RETRY_ERR  = 0;
   // ----------------------------------------------------------------
   // frame layout and counts
   // ----------------------------------------------------------------
   localparam logic [2:0]  DA_LAST_IDX    = 3'h5;
   localparam logic [10:0] LEN_HI_IDX     = 11'h00c;
   localparam logic [10:0] LEN_LO_IDX     = 11'h00d;
   localparam logic [15:0] MIN_LEN        = 16'h002e;
   localparam logic [4:0]  MAX_ATTEMPTS   = 5'h10;
   localparam logic [47:0] BROADCAST_DISABLE_ADDR     = 48'hffff_ffff_ffff;
   localparam logic [31:0] CRC_POLY       = 32'h04c1_1db7;
   localparam int unsigned FIFO_WIDTH     = 10;
   localparam int unsigned FIFO_DEPTH     = 4;
   localparam int unsigned FIFO_CW        = 3;
   localparam logic [2:0]  FIFO_SPACE_LIM = 3'h2;

   typedef enum logic [3:0] {
      RX_COLLECT = 4'b0001,
      RX_REPLAY  = 4'b0010,
      RX_PASS    = 4'b0100,
      RX_DROP    = 4'b1000
   } hmrt_rx_state_type;
endpackage
`default_nettype wire

// File: common/hmrt_fifo_if.sv
// interface between the receive path and its byte fifo
`default_nettype none
interface hmrt_fifo_if #(parameter int unsigned WIDTH = 10,
                         parameter int unsigned CW    = 3);
   logic [WIDTH-1:0] in_data;
   logic             in_valid;
   logic             in_ready;
   logic [WIDTH-1:0] out_data;
   logic             out_valid;
   logic             out_ready;
   logic [CW-1:0]    count;
   modport fifo (input in_data, in_valid, out_ready,
                 output in_ready, out_data, out_valid, count);
   modport user (output in_data, in_valid, out_ready,
                 input in_ready, out_data, out_valid, count);
endinterface
`default_nettype wire

// File: src/hmrt_fifo.sv
// small flip-flop fifo with valid and ready on both sides
`default_nettype none
module hmrt_fifo #(
   parameter int unsigned WIDTH = 10,
   parameter int unsigned DEPTH = 4,
   parameter int unsigned CW    = 3
) (
   input wire logic clk,
   input wire logic rst_n,
   hmrt_fifo_if.fifo bus
);
   localparam int unsigned PW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem      [DEPTH];
   logic [WIDTH-1:0] next_mem [DEPTH];
   logic [PW-1:0]    wp;
   logic [PW-1:0]    rp;
   logic [PW-1:0]    next_wp;
   logic [PW-1:0]    next_rp;
   logic [CW-1:0]    cnt;
   logic [CW-1:0]    next_cnt;
   logic             push;
   logic             pop;

   function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
      return (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
   endfunction

   assign bus.in_ready  = (cnt != CW'(DEPTH));
   assign bus.out_valid = (cnt != '0);
   assign bus.out_data  = mem[rp];
   assign bus.count     = cnt;

   always_comb begin
      push     = bus.in_valid & bus.in_ready;
      pop      = bus.out_valid & bus.out_ready;
      next_mem = mem;
      next_wp  = wp;
      next_rp  = rp;
      next_cnt = cnt;
      if (push) begin
         next_mem[wp] = bus.in_data;
         next_wp      = bump(wp);
      end
      if (pop) begin
         next_rp = bump(rp);
      end
      if (push && !pop) begin
         next_cnt = cnt + CW'(1);
      end else if (pop && !push) begin
         next_cnt = cnt - CW'(1);
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < DEPTH; i++) begin
            mem[i] <= '0;
         end
         wp  <= '0;
         rp  <= '0;
         cnt <= '0;
      end else begin
         mem <= next_mem;
         wp  <= next_wp;
         rp  <= next_rp;
         cnt <= next_cnt;
      end
   end
endmodule
`default_nettype wire

// File: src/hmrt_mac_ctrl.sv
// host mac receive filter, pad strip and transmit retry control
//
// Chosen here: the register addresses and the APB slave port.
`default_nettype none
module hmrt_mac_ctrl
   import hmrt_pkg::*;
(
   input  wire logic                         MCLK,
   input  wire logic                         RST_N,
   input  wire logic                         PSEL,
   input  wire logic                         PENABLE,
   input  wire logic                         PWRITE,
   input  wire logic [hmrt_pkg::PADDR_W-1:0] PADDR,
   input  wire logic [hmrt_pkg::DATA_W-1:0]  PWDATA,
   output logic      [hmrt_pkg::DATA_W-1:0]  PRDATA,
   output logic                              PREADY,
   output logic                              PSLVERR,
   input  wire logic                         RX_VALID,
   output logic                              RX_READY,
   input  wire logic [7:0]                   RX_DATA,
   input  wire logic                         RX_LAST,
   input  wire logic                         RX_BAD,
   output logic                              RXO_VALID,
   input  wire logic                         RXO_READY,
   output logic      [7:0]                   RXO_DATA,
   output logic                              RXO_LAST,
   output logic                              RXO_ABORT,
   output logic                              WAKE,
   input  wire logic                         TX_ATTEMPT_END,
   input  wire logic                         TX_COLLIDED,
   output logic                              TX_RETRY,
   output logic                              TX_NEXT,
   output logic                              TX_RETRY_ERR
);
   import hmrt_pkg::*;

   // ----------------------------------------------------------------
   // reset release
   // ----------------------------------------------------------------
   logic rst_meta;
   logic rst_n;

   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         rst_meta <= 1'b0;
         rst_n    <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n    <= rst_meta;
      end
   end

   default clocking @(posedge MCLK); endclocking
   default disable iff (!rst_n);

   // ----------------------------------------------------------------
   // register file over apb
   // ----------------------------------------------------------------
   logic [31:0] control;
   logic [15:0] addr_high;
   logic [31:0] addr_low;
   logic [31:0] hash_high;
   logic [31:0] hash_low;
   logic        wake_en;
   logic [31:0] next_control;
   logic [15:0] next_addr_high;
   logic [31:0] next_addr_low;
   logic [31:0] next_hash_high;
   logic [31:0] next_hash_low;
   logic        next_wake_en;
   logic [31:0] next_prdata;
   logic        next_pready;
   logic        next_pslverr;
   logic        wr_en;
   logic        err_clear;
   logic [4:0]  attempts;
   logic [9:0]  idx;

   function automatic logic addr_ok(input logic [PADDR_W-1:0] a);
      logic [9:0] i;
      i = a[PADDR_W-1:2];
      return (a[1:0] == 2'h0) &&
             (i == IDX_CONTROL || i == IDX_ADDR_HIGH ||
              i == IDX_ADDR_LOW || i == IDX_HASH_HIGH ||
              i == IDX_HASH_LOW || i == IDX_WAKEUP ||
              i == IDX_TX_STATUS);
   endfunction

   always_comb begin
      idx            = PADDR[PADDR_W-1:2];
      wr_en          = PSEL & PENABLE & PREADY & PWRITE & addr_ok(PADDR);
      next_control   = control;
      next_addr_high = addr_high;
      next_addr_low  = addr_low;
      next_hash_high = hash_high;
      next_hash_low  = hash_low;
      next_wake_en   = wake_en;
      err_clear      = 1'b0;
      if (wr_en) begin
         unique case (idx)
            IDX_CONTROL:   next_control   = PWDATA & CONTROL_MASK;
            IDX_ADDR_HIGH: next_addr_high = PWDATA[15:0];
            IDX_ADDR_LOW:  next_addr_low  = PWDATA;
            IDX_HASH_HIGH: next_hash_high = PWDATA;
            IDX_HASH_LOW:  next_hash_low  = PWDATA;
            IDX_WAKEUP:    next_wake_en   = PWDATA[BIT_WAKE_EN];
            default:       err_clear      = PWDATA[BIT_RETRY_ERR];
         endcase
      end
      // answer in the access cycle right after setup
      next_pready  = PSEL & ~PENABLE;
      next_pslverr = PSEL & ~PENABLE & ~addr_ok(PADDR);
      next_prdata  = PRDATA;
      if (PSEL && !PENABLE) begin
         next_prdata = 32'h0000_0000;
         if (addr_ok(PADDR)) begin
            unique case (idx)
               IDX_CONTROL:   next_prdata = control;
               IDX_ADDR_HIGH: next_prdata = {16'h0000, addr_high};
               IDX_ADDR_LOW:  next_prdata = addr_low;
               IDX_HASH_HIGH: next_prdata = hash_high;
               IDX_HASH_LOW:  next_prdata = hash_low;
               IDX_WAKEUP:    next_prdata = {31'h0, wake_en};
               default:       next_prdata = {26'h0, attempts,
                                             TX_RETRY_ERR};
            endcase
         end
      end
   end

   always_ff @(posedge MCLK or negedge rst_n) begin
      if (!rst_n) begin
         control   <= CONTROL_RESET;
         addr_high <= 16'h0000;
         addr_low  <= 32'h0000_0000;
         hash_high <= 32'h0000_0000;
         hash_low  <= 32'h0000_0000;
         wake_en   <= 1'b0;
         PRDATA    <= 32'h0000_0000;
         PREADY    <= 1'b0;
         PSLVERR   <= 1'b0;
      end else begin
         control   <= next_control;
         addr_high <= next_addr_high;
         addr_low  <= next_addr_low;
         hash_high <= next_hash_high;
         hash_low  <= next_hash_low;
         wake_en   <= next_wake_en;
         PRDATA    <= next_prdata;
         PREADY    <= next_pready;
         PSLVERR   <= next_pslverr;
      end
   end

   a_ctrl_reserved_zero: assert property (
      (control & ~CONTROL_MASK) == 32'h0)
      else $error("reserved control bit set");
   a_apb_unmapped: assert property (
      PSEL && !PENABLE && !addr_ok(PADDR) |=> PREADY && PSLVERR)
      else $error("unmapped access not refused");

   // ----------------------------------------------------------------
   // receive filter and pad strip
   // ----------------------------------------------------------------
   hmrt_fifo_if #(.WIDTH(FIFO_WIDTH), .CW(FIFO_CW)) fq ();

   hmrt_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH), .CW(FIFO_CW)) u_fifo (
      .clk   (MCLK),
      .rst_n (rst_n),
      .bus   (fq.fifo)
   );

   hmrt_rx_state_type state;
   hmrt_rx_state_type next_state;
   logic [7:0]  da_buf      [6];
   logic [7:0]  next_da_buf [6];
   logic [2:0]  cidx;
   logic [2:0]  next_cidx;
   logic [10:0] cnt;
   logic [10:0] next_cnt;
   logic [15:0] len;
   logic [15:0] next_len;
   logic [15:0] len_eff;
   logic        hold_last;
   logic        hold_bad;
   logic        next_hold_last;
   logic        next_hold_bad;
   logic        next_rx_ready;
   logic        next_wake;
   logic        fire;
   logic        decide;
   logic        cut;
   logic        accept;
   logic        hash_hit;
   logic        perfect_hit;
   logic        is_broadcast_disable;
   logic [47:0] da_now;
   logic [5:0]  hidx;
   logic        next_o_valid;
   logic [9:0]  next_o_word;

   function automatic logic [5:0] hash_index(input logic [47:0] da);
      logic [31:0] c;
      c = 32'hffff_ffff;
      for (int i = 0; i < 48; i++) begin
         if (c[31] ^ da[i]) begin
            c = {c[30:0], 1'b0} ^ CRC_POLY;
         end else begin
            c = {c[30:0], 1'b0};
         end
      end
      return c[31:26];
   endfunction

   assign fq.out_ready = ~RXO_VALID | RXO_READY;

   always_comb begin
      fire        = RX_VALID & RX_READY;
      da_now      = {RX_DATA, da_buf[4], da_buf[3], da_buf[2],
                     da_buf[1], da_buf[0]};
      decide      = (state == RX_COLLECT) && fire && (cidx == DA_LAST_IDX);
      is_broadcast_disable    = (da_now == BROADCAST_DISABLE_ADDR);
      hidx        = hash_index(da_now);
      hash_hit    = hidx[5] ? hash_high[hidx[4:0]] : hash_low[hidx[4:0]];
      perfect_hit = (da_now == {addr_high, addr_low});
      if (is_broadcast_disable) begin
         accept = ~control[BIT_BROADCAST_DISABLE_DIS];
      end else if (da_now[0]) begin
         accept = (control[BIT_HASH_PERF] | control[BIT_HASH_ONLY]) ?
                  hash_hit : perfect_hit;
      end else begin
         accept = control[BIT_HASH_ONLY] ? hash_hit : perfect_hit;
      end
      len_eff = (cnt == LEN_LO_IDX) ? {len[15:8], RX_DATA} : len;
      cut = control[BIT_PAD_STRIP] && (cnt >= LEN_LO_IDX) &&
            (len_eff < MIN_LEN) &&
            (17'(cnt) == 17'(len_eff) + 17'(LEN_LO_IDX));
      next_state     = state;
      next_da_buf    = da_buf;
      next_cidx      = cidx;
      next_cnt       = cnt;
      next_len       = len;
      next_hold_last = hold_last;
      next_hold_bad  = hold_bad;
      next_wake      = decide & is_broadcast_disable & wake_en;
      fq.in_valid    = 1'b0;
      fq.in_data     = '0;
      unique case (state)
         RX_COLLECT: if (fire) begin
            next_da_buf[cidx] = RX_DATA;
            next_cidx         = cidx + 3'h1;
            if (decide) begin
               next_cidx      = 3'h0;
               next_hold_last = RX_LAST;
               next_hold_bad  = RX_BAD;
               next_state     = accept ? RX_REPLAY :
                                (RX_LAST ? RX_COLLECT : RX_DROP);
            end else if (RX_LAST) begin
               next_cidx = 3'h0; // too short to filter: dropped
            end
         end
         RX_REPLAY: begin
            fq.in_valid = 1'b1;
            fq.in_data  = {(cidx == DA_LAST_IDX) & hold_last & hold_bad &
                           ~control[BIT_PASS_BAD],
                           (cidx == DA_LAST_IDX) & hold_last, da_buf[cidx]};
            if (fq.in_ready) begin
               next_cnt  = cnt + 11'h1;
               next_cidx = cidx + 3'h1;
               if (cidx == DA_LAST_IDX) begin
                  next_cidx  = 3'h0;
                  next_state = hold_last ? RX_COLLECT : RX_PASS;
               end
            end
         end
         RX_PASS: if (fire) begin
            // space is guaranteed by the registered ready
            fq.in_valid = 1'b1;
            fq.in_data  = {RX_LAST & RX_BAD & ~control[BIT_PASS_BAD],
                           RX_LAST | cut, RX_DATA};
            next_cnt    = cnt + 11'h1;
            if (cnt == LEN_HI_IDX) begin
               next_len[15:8] = RX_DATA;
            end
            if (cnt == LEN_LO_IDX) begin
               next_len[7:0] = RX_DATA;
            end
            if (RX_LAST) begin
               next_state = RX_COLLECT;
            end else if (cut) begin
               next_state = RX_DROP;
            end
         end
         RX_DROP: if (fire && RX_LAST) begin
            next_state = RX_COLLECT;
         end
      endcase
      if (next_state == RX_COLLECT && state != RX_COLLECT) begin
         next_cnt = 11'h000;
         next_len = 16'h0000;
      end
      next_rx_ready = (next_state != RX_REPLAY) &&
                      (fq.count <= FIFO_SPACE_LIM);
      next_o_valid  = RXO_VALID;
      next_o_word   = {RXO_ABORT, RXO_LAST, RXO_DATA};
      if (fq.out_ready) begin
         next_o_valid = fq.out_valid;
         next_o_word  = fq.out_data;
      end
   end

   always_ff @(posedge MCLK or negedge rst_n) begin
      if (!rst_n) begin
         state     <= RX_COLLECT;
         for (int i = 0; i < 6; i++) begin
            da_buf[i] <= 8'h00;
         end
         cidx      <= 3'h0;
         cnt       <= 11'h000;
         len       <= 16'h0000;
         hold_last <= 1'b0;
         hold_bad  <= 1'b0;
         RX_READY  <= 1'b0;
         WAKE      <= 1'b0;
         RXO_VALID <= 1'b0;
         RXO_ABORT <= 1'b0;
         RXO_LAST  <= 1'b0;
         RXO_DATA  <= 8'h00;
      end else begin
         state     <= next_state;
         da_buf    <= next_da_buf;
         cidx      <= next_cidx;
         cnt       <= next_cnt;
         len       <= next_len;
         hold_last <= next_hold_last;
         hold_bad  <= next_hold_bad;
         RX_READY  <= next_rx_ready;
         WAKE      <= next_wake;
         RXO_VALID <= next_o_valid;
         {RXO_ABORT, RXO_LAST, RXO_DATA} <= next_o_word;
      end
   end

   a_broadcast_disable_reject: assert property (
      decide && is_broadcast_disable && control[BIT_BROADCAST_DISABLE_DIS] |=> state != RX_REPLAY)
      else $error("broadcast accepted while disabled");
   a_broadcast_disable_wake: assert property (
      decide && is_broadcast_disable && wake_en |=> WAKE ##1 !WAKE)
      else $error("broadcast wake-up missed");
   a_perfect_miss: assert property (
      decide && !is_broadcast_disable && !control[BIT_HASH_PERF] &&
      !control[BIT_HASH_ONLY] && !perfect_hit |=> state != RX_REPLAY)
      else $error("perfect filter let a stranger through");
   a_hash_only_hit: assert property (
      decide && !is_broadcast_disable && control[BIT_HASH_ONLY] |=>
      (state == RX_REPLAY) == $past(hash_hit))
      else $error("hash-only decision wrong");
   a_pad_cut_drop: assert property (
      state == RX_PASS && fire && cut && !RX_LAST |=> state == RX_DROP)
      else $error("padded frame not cut");
   a_bad_frame_pass: assert property (
      state == RX_PASS && fire && RX_LAST && control[BIT_PASS_BAD] |->
      fq.in_valid && !fq.in_data[9])
      else $error("bad frame aborted despite pass-bad");

   // ----------------------------------------------------------------
   // transmit retry
   // ----------------------------------------------------------------
   logic [4:0] next_attempts;
   logic       next_tx_retry;
   logic       next_tx_next;
   logic       next_retry_err;

   always_comb begin
      next_attempts  = attempts;
      next_tx_retry  = 1'b0;
      next_tx_next   = 1'b0;
      next_retry_err = TX_RETRY_ERR & ~err_clear;
      if (TX_ATTEMPT_END) begin
         if (!TX_COLLIDED) begin
            next_tx_next  = 1'b1;
            next_attempts = 5'h00;
         end else if (control[BIT_RETRY_DIS] ||
                      attempts == MAX_ATTEMPTS - 5'h1) begin
            next_tx_next   = 1'b1;
            next_retry_err = 1'b1; // set wins over a clear
            next_attempts  = 5'h00;
         end else begin
            next_tx_retry = 1'b1;
            next_attempts = attempts + 5'h01;
         end
      end
   end

   always_ff @(posedge MCLK or negedge rst_n) begin
      if (!rst_n) begin
         attempts     <= 5'h00;
         TX_RETRY     <= 1'b0;
         TX_NEXT      <= 1'b0;
         TX_RETRY_ERR <= 1'b0;
      end else begin
         attempts     <= next_attempts;
         TX_RETRY     <= next_tx_retry;
         TX_NEXT      <= next_tx_next;
         TX_RETRY_ERR <= next_retry_err;
      end
   end

   a_retry_off_once: assert property (
      TX_ATTEMPT_END && TX_COLLIDED && control[BIT_RETRY_DIS] |=>
      TX_NEXT && TX_RETRY_ERR && !TX_RETRY)
      else $error("retry disabled but frame retried");
   a_retry_sixteen: assert property (
      TX_ATTEMPT_END && TX_COLLIDED && !control[BIT_RETRY_DIS] |=>
      (TX_RETRY == ($past(attempts) < 5'd15)) &&
      (TX_NEXT == ($past(attempts) == 5'd15)))
      else $error("retry count not sixteen attempts");
endmodule
`default_nettype wire

// File: verification/hmrt_fabric_model.sv
// switch fabric port model that feeds frames byte by byte
`default_nettype none
module hmrt_fabric_model (
   input  wire logic  clk,
   input  wire logic  rx_ready,
   output logic       rx_valid,
   output logic [7:0] rx_data,
   output logic       rx_last,
   output logic       rx_bad
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] mem [0:63];
   initial {rx_valid, rx_data, rx_last, rx_bad} = '0;
   // each byte stands until the block takes it
   task automatic send(input int len, input logic bad);
      for (int i = 0; i < len; i++) begin
         rx_valid <= 1'b1;
         rx_data  <= mem[i];
         rx_last  <= (i == len - 1);
         rx_bad   <= bad && (i == len - 1);
         do @(posedge clk); while (rx_ready !== 1'b1);
      end
      // idle data is scrambled so a stale byte never looks valid
      rx_valid <= 1'b0;
      rx_data  <= ~mem[len - 1];
      rx_last  <= 1'b0;
      rx_bad   <= 1'b0;
   endtask
endmodule
`default_nettype wire

// File: verification/testbench.sv
// self-checking testbench of the host mac filter and retry block
`default_nettype none
module testbench import hmrt_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk, rst_n, psel, pen, pwr, pready, pslverr, rxv, rxr, rxl, rxb;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, q;
   logic [7:0]  rxd, rxo_d;
   logic rxo_v, rxo_r, rxo_l, rxo_a, wake, tae, tcol, trt, tnx, terr;
   logic ab, se, stall;
   int errors, n_tests, nb, nw, pos;
   hmrt_mac_ctrl hmrt_mac_ctrl_inst (.MCLK(mclk), .RST_N(rst_n),
      .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(paddr),
      .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
      .PSLVERR(pslverr), .RX_VALID(rxv), .RX_READY(rxr), .RX_DATA(rxd),
      .RX_LAST(rxl), .RX_BAD(rxb), .RXO_VALID(rxo_v),
      .RXO_READY(rxo_r), .RXO_DATA(rxo_d), .RXO_LAST(rxo_l),
      .RXO_ABORT(rxo_a), .WAKE(wake), .TX_ATTEMPT_END(tae),
      .TX_COLLIDED(tcol), .TX_RETRY(trt), .TX_NEXT(tnx),
      .TX_RETRY_ERR(terr));
   hmrt_fabric_model hmrt_fabric_model_inst (.clk(mclk), .rx_ready(rxr),
      .rx_valid(rxv), .rx_data(rxd), .rx_last(rxl), .rx_bad(rxb));
   initial begin
      mclk = 0;
      forever #2 mclk = ~mclk;
   end
   // host side stalls every other cycle when asked, to back up the fifo
   always @(posedge mclk) begin
      rxo_r <= !stall || !rxo_r;
      if (rxo_v === 1'b1 && rxo_r === 1'b1) begin
         chk("rx data", hmrt_fabric_model_inst.mem[pos], rxo_d);
         nb++;
         pos++;
         if (rxo_l === 1'b1) begin
            ab = rxo_a;
            pos = 0;
         end
      end
      if (wake === 1'b1) nw++;
   end
   task automatic chk(input string s, input logic [31:0] e, g);
      n_tests++;
      if (g !== e) begin
         errors++;
         $display("BAD %s expected %h seen %h", s, e, g);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      psel <= 1; pwr <= w; paddr <= a; pwdata <= d; pen <= 0;
      @(posedge mclk);
      pen <= 1;
      do @(posedge mclk); while (pready !== 1'b1);
      q = prdata;
      se = pslverr;
      psel <= 0;
      pen <= 0;
      @(posedge mclk);
   endtask
   task automatic rx(input logic [47:0] d, input logic [15:0] ln,
                     input int n, input logic bad, input int eb,
                     input logic ea);
      int b0;
      b0 = nb;
      for (int i = 0; i < 64; i++) hmrt_fabric_model_inst.mem[i] = 8'(i);
      for (int i = 0; i < 6; i++) hmrt_fabric_model_inst.mem[i] = d[8*i+:8];
      hmrt_fabric_model_inst.mem[12] = ln[15:8];
      hmrt_fabric_model_inst.mem[13] = ln[7:0];
      hmrt_fabric_model_inst.send(n, bad);
      repeat (60) @(posedge mclk);
      chk("rx bytes", eb, nb - b0);
      if (eb > 0) chk("rx abort", ea, ab);
   endtask
   task automatic txa(input logic col);
      tae <= 1; tcol <= col;
      @(posedge mclk);
      tae <= 0;
      @(negedge mclk);
      @(posedge mclk);
   endtask
   task automatic s_regs;
      apb(0, 12'h004, 0); chk("ctrl reset", 0, q);
      apb(1, 12'h004, 32'hffff_ffff);
      apb(0, 12'h004, 0); chk("ctrl mask", CONTROL_MASK, q);
      apb(0, 12'h000, 0); chk("unmapped", 1, se);
   endtask
   task automatic s_rx;
      apb(1, 12'h008, 32'h0000_0605);
      apb(1, 12'h00c, 32'h0403_0201);
      apb(1, 12'h004, 0);
      rx(48'h0605_0403_0201, 16'h0040, 20, 0, 20, 0);
      rx(48'h0605_0403_0200, 16'h0040, 20, 0, 0, 0);
      rx(48'h0605_0403_0201, 16'h0040, 20, 1, 20, 1);
      apb(1, 12'h004, 32'h0001_0000);
      rx(48'h0605_0403_0201, 16'h0040, 20, 1, 20, 0);
      apb(1, 12'h010, 32'hffff_ffff);
      apb(1, 12'h014, 32'hffff_ffff);
      apb(1, 12'h004, 32'h0000_8000);
      rx(48'h0605_0403_0200, 16'h0040, 20, 0, 20, 0);
      apb(1, 12'h004, 32'h0000_2000);
      rx(48'h0605_0403_0203, 16'h0040, 20, 0, 20, 0);
      rx(48'h0605_0403_0200, 16'h0040, 20, 0, 0, 0);
      apb(1, 12'h004, 32'h0000_0800);
      rx(BROADCAST_DISABLE_ADDR, 16'h0040, 20, 0, 0, 0);
      apb(1, 12'h030, 1);
      nw = 0;
      rx(BROADCAST_DISABLE_ADDR, 16'h0040, 20, 0, 0, 0);
      chk("wake", 1, nw);
      apb(1, 12'h004, 0);
      rx(BROADCAST_DISABLE_ADDR, 16'h0040, 20, 0, 20, 0);
      stall = 1;
      apb(1, 12'h004, 32'h0000_0100);
      rx(48'h0605_0403_0201, 16'h0002, 30, 0, 16, 0);
      rx(48'h0605_0403_0201, 16'h002e, 64, 0, 64, 0);
      apb(1, 12'h004, 0);
      rx(48'h0605_0403_0201, 16'h0002, 30, 0, 30, 0);
      stall = 0;
   endtask
   task automatic s_tx;
      int r;
      r = 0;
      for (int i = 0; i < 15; i++) begin
         txa(1);
         r += (trt === 1'b1);
      end
      chk("retries", 15, r);
      chk("no err yet", 0, terr);
      txa(1); chk("next at 16", 1, tnx);
      chk("err at 16", 1, terr);
      apb(1, 12'h040, 1);
      apb(1, 12'h004, 32'h0000_0400);
      txa(1); chk("single next", 1, tnx);
      chk("single err", 1, terr);
   endtask
   task automatic results;
      if (errors == 0 && n_tests > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   initial begin
      {rst_n, psel, pen, pwr, tae, tcol, stall} = '0;
      paddr = 0; pwdata = 0; rxo_r = 1;
      repeat (10) @(posedge mclk);
      rst_n <= 1;
      repeat (5) @(posedge mclk);
      s_regs;
      s_rx;
      s_tx;
      results;
   end
   initial begin
      repeat (20000) @(posedge mclk);
      errors++;
      results;
   end
endmodule
`default_nettype wire
